// ===== include/frr_regs.svh
// Command codes, field layout, reset values and timing of the fault response block
// Functional notes
// - Every response mode pulls the alert line low and sets the fault status bit.
// - Response 10 disables the output at once, then retries per bits 5:3.
// - Cold fault, response 11: disable now, resume once temperature exceeds cold warning level.
// - Input-high fault, response 11: disable now, resume once input falls below warning level.
// - Retry count 000: no restart; output stays off until faults are cleared.
// - Retry count 111: retry forever until disabled or another fault shuts down.
// - Other retry counts: restart exactly that many times.
// - Delay between retries is (bits 2:0 + 1) times 35 ms.
// - Hold 16-bit Linear input-high trip level; input above it is a fault.
// - Fault action settings are byte commands, read and written with byte transfers.
// - Hold 16-bit Linear cold warning level as the cold resume point.
// - Hold 16-bit Linear input-high warning level as the input-high resume point.
`ifndef FRR_REGS_SVH
`define FRR_REGS_SVH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define FRR_CMD_CLEAR      8'h03
`define FRR_CMD_COLD_WARN  8'h52
`define FRR_CMD_COLD_TRIP  8'h53
`define FRR_CMD_COLD_ACT   8'h54
`define FRR_CMD_VIN_TRIP   8'h55
`define FRR_CMD_VIN_ACT    8'h56
`define FRR_CMD_VIN_WARN   8'h57
`define FRR_CMD_STATUS     8'h7E

// ----------------------------------------
// Action byte fields
// ----------------------------------------
`define FRR_RESP_HI        7
`define FRR_RESP_LO        6
`define FRR_RETRY_HI       5
`define FRR_RETRY_LO       3
`define FRR_TIME_HI        2
`define FRR_TIME_LO        0
`define FRR_RESP_RETRY     2'h2
`define FRR_RESP_RESUME    2'h3
`define FRR_RETRY_NONE     3'h0
`define FRR_RETRY_CONT     3'h7

// ----------------------------------------
// Status word fields
// ----------------------------------------
`define FRR_ST_COLD        0
`define FRR_ST_VIN         1
`define FRR_ST_TRIES_C_LO  2
`define FRR_ST_TRIES_V_LO  5
`define FRR_ST_LINE_LOW    15

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FRR_ACT_RST        8'hC0
`define FRR_COLD_TRIP_RST  16'h07D8
`define FRR_COLD_WARN_RST  16'h07E7
`define FRR_VIN_TRIP_RST   16'h000F
`define FRR_VIN_WARN_RST   16'h000E

// ----------------------------------------
// Timing
// ----------------------------------------
`define FRR_RETRY_STEP_MS  35
`define FRR_CLK_PERIOD_NS  4
`define FRR_RETRY_STEP_CYC (`FRR_RETRY_STEP_MS * 1000000 / `FRR_CLK_PERIOD_NS)

`endif

// ===== include/frr_pkg.sv
// Types and Linear-format helper of the fault response block
package frr_pkg;

  typedef enum logic [2:0] {
    FRR_RUN    = 3'b000,
    FRR_RESUME = 3'b001,
    FRR_DELAY  = 3'b010,
    FRR_PROBE  = 3'b011,
    FRR_LATCH  = 3'b100
  } frr_state_t;

  typedef struct packed {
    frr_state_t  st;
    logic [2:0]  tries;
    logic [31:0] cnt;
    logic        shut;
    logic        evt;
  } frr_chan_t;

  typedef struct packed {
    frr_chan_t [1:0] ch;
    logic            out_en;
  } frr_core_t;

  typedef struct packed {
    logic [7:0]  cold_act;
    logic [15:0] cold_warn;
    logic [15:0] cold_trip;
    logic [15:0] vin_trip;
    logic [7:0]  vin_act;
    logic [15:0] vin_warn;
    logic [1:0]  stat;
    logic        clr;
    logic        rsp_valid;
    logic        rsp_err;
    logic [15:0] rdata;
    logic [1:0]  line_sync;
    logic        alert_oe;
    logic        alert_o;
  } frr_regs_t;

  // Linear value scaled by 2^16 as a signed fixed-point number
  function automatic logic signed [47:0] frr_lin_to_fix(input logic [15:0] v);
    logic signed [47:0] m;
    logic [4:0]         e;
    m = {{37{v[10]}}, v[10:0]};
    e = v[15:11] + 5'h10;
    return m <<< e;
  endfunction

endpackage

// ===== include/frr_cfg_if.sv
// Settings and fault events passed between register file and retry engines
`timescale 1ns/1ns
interface frr_cfg_if;
  logic [7:0]  cold_act;
  logic [15:0] cold_warn;
  logic [15:0] cold_trip;
  logic [15:0] vin_trip;
  logic [7:0]  vin_act;
  logic [15:0] vin_warn;
  logic        clr;
  logic [1:0]  evt;
  logic [5:0]  tries;

  modport regs (output cold_act, cold_warn, cold_trip, vin_trip, vin_act, vin_warn, clr,
                input  evt, tries);
  modport core (input  cold_act, cold_warn, cold_trip, vin_trip, vin_act, vin_warn, clr,
                output evt, tries);
endinterface

// ===== src/frr_lin_cmp.sv
// Greater-than compare of two Linear-format values
`timescale 1ns/1ns
module frr_lin_cmp (
  input  wire logic [15:0] a,
  input  wire logic [15:0] b,
  output wire logic        a_gt_b
);
  assign a_gt_b = frr_pkg::frr_lin_to_fix(a) > frr_pkg::frr_lin_to_fix(b);
endmodule // frr_lin_cmp

// ===== src/frr_regs.sv
// Command register file, fault status and alert line driver
`timescale 1ns/1ns
`include "frr_regs.svh"
module frr_regs (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic        cmd_word,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] cmd_wdata,
  input  wire logic        alert_line_i,
  output wire logic        rsp_valid,
  output wire logic        rsp_err,
  output wire logic [15:0] rsp_rdata,
  output wire logic        alert_line_o,
  output wire logic        alert_line_oe,
  frr_cfg_if.regs          cfg
);
  frr_pkg::frr_regs_t cur;
  frr_pkg::frr_regs_t nxt;

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  always_comb begin
    logic [15:0] stat_w;
    stat_w = 16'h0000;
    stat_w[`FRR_ST_COLD] = cur.stat[0];
    stat_w[`FRR_ST_VIN] = cur.stat[1];
    stat_w[`FRR_ST_TRIES_C_LO +: 3] = cfg.tries[2:0];
    stat_w[`FRR_ST_TRIES_V_LO +: 3] = cfg.tries[5:3];
    stat_w[`FRR_ST_LINE_LOW] = ~cur.line_sync[1];
    nxt = cur;
    nxt.rsp_valid = 1'b0;
    nxt.rsp_err = 1'b0;
    nxt.clr = 1'b0;
    nxt.line_sync = {cur.line_sync[0], alert_line_i};
    if (cmd_valid) begin
      nxt.rsp_valid = 1'b1;
      nxt.rdata = 16'h0000;
      case (cmd_code)
        `FRR_CMD_CLEAR: begin
          if (cmd_write) nxt.clr = 1'b1;
          else nxt.rsp_err = 1'b1;
        end
        `FRR_CMD_COLD_ACT: begin
          if (cmd_word) nxt.rsp_err = 1'b1;
          else if (cmd_write) nxt.cold_act = cmd_wdata[7:0];
          else nxt.rdata = {8'h00, cur.cold_act};
        end
        `FRR_CMD_VIN_ACT: begin
          if (cmd_word) nxt.rsp_err = 1'b1;
          else if (cmd_write) nxt.vin_act = cmd_wdata[7:0];
          else nxt.rdata = {8'h00, cur.vin_act};
        end
        `FRR_CMD_VIN_TRIP: begin
          if (!cmd_word) nxt.rsp_err = 1'b1;
          else if (cmd_write) nxt.vin_trip = cmd_wdata;
          else nxt.rdata = cur.vin_trip;
        end
        `FRR_CMD_COLD_WARN: begin
          if (!cmd_word) nxt.rsp_err = 1'b1;
          else if (cmd_write) nxt.cold_warn = cmd_wdata;
          else nxt.rdata = cur.cold_warn;
        end
        `FRR_CMD_VIN_WARN: begin
          if (!cmd_word) nxt.rsp_err = 1'b1;
          else if (cmd_write) nxt.vin_warn = cmd_wdata;
          else nxt.rdata = cur.vin_warn;
        end
        `FRR_CMD_COLD_TRIP: begin
          if (!cmd_word) nxt.rsp_err = 1'b1;
          else if (cmd_write) nxt.cold_trip = cmd_wdata;
          else nxt.rdata = cur.cold_trip;
        end
        `FRR_CMD_STATUS: begin
          if (cmd_write || !cmd_word) nxt.rsp_err = 1'b1;
          else nxt.rdata = stat_w;
        end
        default: nxt.rsp_err = 1'b1;
      endcase
    end
    // Set wins over a clear in the same cycle
    nxt.stat = (nxt.clr ? 2'b00 : cur.stat) | cfg.evt;
    nxt.alert_oe = |nxt.stat;
    nxt.alert_o = 1'b0;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur <= '{cold_act: `FRR_ACT_RST, vin_act: `FRR_ACT_RST,
               cold_trip: `FRR_COLD_TRIP_RST, cold_warn: `FRR_COLD_WARN_RST,
               vin_trip: `FRR_VIN_TRIP_RST, vin_warn: `FRR_VIN_WARN_RST,
               line_sync: 2'h3, default: '0};
    end else begin
      cur <= nxt;
    end
  end

  assign cfg.cold_act  = cur.cold_act;
  assign cfg.cold_warn = cur.cold_warn;
  assign cfg.cold_trip = cur.cold_trip;
  assign cfg.vin_trip  = cur.vin_trip;
  assign cfg.vin_act   = cur.vin_act;
  assign cfg.vin_warn  = cur.vin_warn;
  assign cfg.clr       = cur.clr;
  assign rsp_valid     = cur.rsp_valid;
  assign rsp_err       = cur.rsp_err;
  assign rsp_rdata     = cur.rdata;
  assign alert_line_o  = cur.alert_o;
  assign alert_line_oe = cur.alert_oe;
endmodule // frr_regs

// ===== src/frr_top.sv
// Fault response top: threshold compare, retry engines and output enable
`timescale 1ns/1ns
`include "frr_regs.svh"
module frr_top #(
  parameter int unsigned RETRY_STEP_CYC = `FRR_RETRY_STEP_CYC
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic        CMD_VALID,
  input  wire logic        CMD_WRITE,
  input  wire logic        CMD_WORD,
  input  wire logic [7:0]  CMD_CODE,
  input  wire logic [15:0] CMD_WDATA,
  output wire logic        RSP_VALID,
  output wire logic        RSP_ERR,
  output wire logic [15:0] RSP_RDATA,
  input  wire logic [15:0] TEMP_LIN,
  input  wire logic [15:0] VIN_LIN,
  input  wire logic        EN_REQ,
  input  wire logic        OTHER_SHUTDOWN,
  output wire logic        OUT_EN,
  input  wire logic        ALERT_LINE_I,
  output wire logic        ALERT_LINE_O,
  output wire logic        ALERT_LINE_OE
);
  frr_cfg_if         cfg ();
  frr_pkg::frr_core_t cur;
  frr_pkg::frr_core_t nxt;
  logic [1:0]        det_w;
  logic [1:0]        rec_w;
  logic [1:0]        oth_w;
  logic [1:0][7:0]   act_w;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  frr_regs u_regs (
    .clk           (CORE_CLK),
    .rst           (RST),
    .cmd_valid     (CMD_VALID),
    .cmd_write     (CMD_WRITE),
    .cmd_word      (CMD_WORD),
    .cmd_code      (CMD_CODE),
    .cmd_wdata     (CMD_WDATA),
    .alert_line_i  (ALERT_LINE_I),
    .rsp_valid     (RSP_VALID),
    .rsp_err       (RSP_ERR),
    .rsp_rdata     (RSP_RDATA),
    .alert_line_o  (ALERT_LINE_O),
    .alert_line_oe (ALERT_LINE_OE),
    .cfg           (cfg.regs)
  );

  // ----------------------------------------
  // Threshold compares
  // ----------------------------------------
  // Cold fault: temperature below cold trip level
  frr_lin_cmp u_cold_det (
    .a      (cfg.cold_trip),
    .b      (TEMP_LIN),
    .a_gt_b (det_w[0])
  );
  // Cold resume: temperature above cold warning level
  frr_lin_cmp u_cold_rec (
    .a      (TEMP_LIN),
    .b      (cfg.cold_warn),
    .a_gt_b (rec_w[0])
  );
  // Input-high fault: input above trip level
  frr_lin_cmp u_vin_det (
    .a      (VIN_LIN),
    .b      (cfg.vin_trip),
    .a_gt_b (det_w[1])
  );
  // Input-high resume: input below warning level
  frr_lin_cmp u_vin_rec (
    .a      (cfg.vin_warn),
    .b      (VIN_LIN),
    .a_gt_b (rec_w[1])
  );

  assign act_w[0] = cfg.cold_act;
  assign act_w[1] = cfg.vin_act;
  assign oth_w[0] = OTHER_SHUTDOWN | cur.ch[1].shut;
  assign oth_w[1] = OTHER_SHUTDOWN | cur.ch[0].shut;

  // Cycles to wait minus one, so the count ends on zero
  function automatic logic [31:0] retry_wait(input logic [2:0] code);
    return (32'(code) + 32'h1) * 32'(RETRY_STEP_CYC) - 32'h1;
  endfunction

  // ----------------------------------------
  // Retry engines, one per fault source
  // ----------------------------------------
  always_comb begin
    nxt = cur;
    for (int c = 0; c < 2; c++) begin
      nxt.ch[c].evt = 1'b0;
      if (!EN_REQ) begin
        // Host disable ends any retry sequence
        nxt.ch[c].st = frr_pkg::FRR_RUN;
        nxt.ch[c].shut = 1'b0;
        nxt.ch[c].tries = 3'h0;
        nxt.ch[c].cnt = 32'h0;
      end else begin
        case (cur.ch[c].st)
          frr_pkg::FRR_RUN: begin
            if (det_w[c]) begin
              nxt.ch[c].evt = 1'b1;
              case (act_w[c][`FRR_RESP_HI:`FRR_RESP_LO])
                `FRR_RESP_RESUME: begin
                  nxt.ch[c].st = frr_pkg::FRR_RESUME;
                  nxt.ch[c].shut = 1'b1;
                end
                `FRR_RESP_RETRY: begin
                  nxt.ch[c].shut = 1'b1;
                  nxt.ch[c].tries = 3'h0;
                  if (act_w[c][`FRR_RETRY_HI:`FRR_RETRY_LO] == `FRR_RETRY_NONE) begin
                    nxt.ch[c].st = frr_pkg::FRR_LATCH;
                  end else begin
                    nxt.ch[c].st = frr_pkg::FRR_DELAY;
                    nxt.ch[c].cnt = retry_wait(act_w[c][`FRR_TIME_HI:`FRR_TIME_LO]);
                  end
                end
                default: begin
                  nxt.ch[c].shut = 1'b0;
                end
              endcase
            end
          end
          frr_pkg::FRR_RESUME: begin
            if (rec_w[c]) begin
              nxt.ch[c].st = frr_pkg::FRR_RUN;
              nxt.ch[c].shut = 1'b0;
            end
          end
          frr_pkg::FRR_DELAY: begin
            if (oth_w[c]) begin
              nxt.ch[c].st = frr_pkg::FRR_LATCH;
            end else if (cur.ch[c].cnt == 32'h0) begin
              nxt.ch[c].st = frr_pkg::FRR_PROBE;
              nxt.ch[c].shut = 1'b0;
              nxt.ch[c].cnt = retry_wait(act_w[c][`FRR_TIME_HI:`FRR_TIME_LO]);
              if (act_w[c][`FRR_RETRY_HI:`FRR_RETRY_LO] != `FRR_RETRY_CONT) begin
                nxt.ch[c].tries = cur.ch[c].tries + 3'h1;
              end
            end else begin
              nxt.ch[c].cnt = cur.ch[c].cnt - 32'h1;
            end
          end
          frr_pkg::FRR_PROBE: begin
            if (det_w[c]) begin
              nxt.ch[c].evt = 1'b1;
              nxt.ch[c].shut = 1'b1;
              if (act_w[c][`FRR_RETRY_HI:`FRR_RETRY_LO] == `FRR_RETRY_CONT ||
                  cur.ch[c].tries < act_w[c][`FRR_RETRY_HI:`FRR_RETRY_LO]) begin
                nxt.ch[c].st = frr_pkg::FRR_DELAY;
                nxt.ch[c].cnt = retry_wait(act_w[c][`FRR_TIME_HI:`FRR_TIME_LO]);
              end else begin
                nxt.ch[c].st = frr_pkg::FRR_LATCH;
              end
            end else if (cur.ch[c].cnt == 32'h0) begin
              nxt.ch[c].st = frr_pkg::FRR_RUN;
              nxt.ch[c].tries = 3'h0;
            end else begin
              nxt.ch[c].cnt = cur.ch[c].cnt - 32'h1;
            end
          end
          frr_pkg::FRR_LATCH: begin
            if (cfg.clr) begin
              nxt.ch[c].st = frr_pkg::FRR_RUN;
              nxt.ch[c].shut = 1'b0;
              nxt.ch[c].tries = 3'h0;
            end
          end
          default: begin
            nxt.ch[c].st = frr_pkg::FRR_RUN;
            nxt.ch[c].shut = 1'b0;
          end
        endcase
      end
    end
    nxt.out_en = EN_REQ & ~OTHER_SHUTDOWN & ~nxt.ch[0].shut & ~nxt.ch[1].shut;
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign cfg.evt   = {cur.ch[1].evt, cur.ch[0].evt};
  assign cfg.tries = {cur.ch[1].tries, cur.ch[0].tries};
  assign OUT_EN    = cur.out_en;
endmodule // frr_top

// ===== testbench/frr_host_model.sv
// Host side of the alert wire: pull-up plus the block's open-drain driver
`timescale 1ns/1ns
module frr_host_model (
  input  wire logic alert_o,
  input  wire logic alert_oe,
  output wire logic alert_wire
);
  // Pull-up wins whenever the block lets go of the wire
  assign alert_wire = alert_oe ? alert_o : 1'b1;
endmodule // frr_host_model

// ===== testbench/frr_monitor.sv
// Port checker of the fault response block, bound to its top
`timescale 1ns/1ns
module frr_monitor #(
  parameter int unsigned RETRY_STEP_CYC = 8
) (
  input wire logic        CORE_CLK,
  input wire logic        RST,
  input wire logic        CMD_VALID,
  input wire logic        CMD_WRITE,
  input wire logic        CMD_WORD,
  input wire logic [7:0]  CMD_CODE,
  input wire logic [15:0] CMD_WDATA,
  input wire logic        RSP_VALID,
  input wire logic        RSP_ERR,
  input wire logic [15:0] VIN_LIN,
  input wire logic        EN_REQ,
  input wire logic        OTHER_SHUTDOWN,
  input wire logic        OUT_EN,
  input wire logic        ALERT_LINE_O,
  input wire logic        ALERT_LINE_OE
);
  logic [15:0] trip_r;
  logic [7:0]  act_r;
  logic        clr_cmd;
  logic        vfault;

  // ------
  // Shadow of input-high settings
  // ------
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      trip_r <= 16'h000F;
      act_r  <= 8'hC0;
    end else if (CMD_VALID && CMD_WRITE && CMD_WORD && CMD_CODE == 8'h55) begin
      trip_r <= CMD_WDATA;
    end else if (CMD_VALID && CMD_WRITE && !CMD_WORD && CMD_CODE == 8'h56) begin
      act_r <= CMD_WDATA[7:0];
    end
  end
  assign clr_cmd = CMD_VALID && CMD_WRITE && CMD_CODE == 8'h03;
  // Only judged while both exponents are zero
  assign vfault  = EN_REQ && VIN_LIN[15:11] == 5'h00 && trip_r[15:11] == 5'h00
                   && $signed(VIN_LIN[10:0]) > $signed(trip_r[10:0]);

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  // ------
  // Assertions
  // ------
  a_rsp_pairs: assert property (##1 RSP_VALID == $past(CMD_VALID))
    else $error("response strobe out of step");
  a_size_err: assert property (CMD_VALID && CMD_WORD && (CMD_CODE == 8'h54 || CMD_CODE == 8'h56) |=> RSP_ERR)
    else $error("word transfer to byte setting accepted");
  a_alert_open: assert property (ALERT_LINE_OE |-> ALERT_LINE_O == 1'b0)
    else $error("alert line driven high");
  a_alert_clear: assert property ($fell(ALERT_LINE_OE) |-> $past(clr_cmd))
    else $error("alert released without clear");
  a_out_gate: assert property (!EN_REQ || OTHER_SHUTDOWN |=> !OUT_EN)
    else $error("output on while disabled");
  a_rise_cause: assert property ($rose(OUT_EN) |-> $past(EN_REQ) && !$past(OTHER_SHUTDOWN))
    else $error("output enabled without request");
  a_vin_off: assert property ($rose(vfault) && OUT_EN && act_r[7] |=> !OUT_EN)
    else $error("output not cut on input-high fault");
  a_vin_alert: assert property ($rose(vfault) |=> ##1 ALERT_LINE_OE)
    else $error("alert late on input-high fault");

  c_vin_fault: cover property ($rose(vfault) && act_r[7]);
  c_out_back: cover property ($rose(OUT_EN));
  c_clear: cover property (clr_cmd);
endmodule // frr_monitor

bind frr_top frr_monitor #(.RETRY_STEP_CYC(RETRY_STEP_CYC)) u_monitor (
  .CORE_CLK(CORE_CLK), .RST(RST), .CMD_VALID(CMD_VALID), .CMD_WRITE(CMD_WRITE), .CMD_WORD(CMD_WORD),
  .CMD_CODE(CMD_CODE), .CMD_WDATA(CMD_WDATA), .RSP_VALID(RSP_VALID), .RSP_ERR(RSP_ERR),
  .VIN_LIN(VIN_LIN), .EN_REQ(EN_REQ), .OTHER_SHUTDOWN(OTHER_SHUTDOWN), .OUT_EN(OUT_EN),
  .ALERT_LINE_O(ALERT_LINE_O), .ALERT_LINE_OE(ALERT_LINE_OE));

// ===== testbench/tb_top.sv
// Self-checking testbench of the fault response block
`timescale 1ns/1ns
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin errors++; $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  localparam int unsigned STEP = 8;
  logic        CORE_CLK = 1'b0;
  logic        RST = 1'b1;
  logic        CMD_VALID = 1'b0;
  logic        CMD_WRITE = 1'b0;
  logic        CMD_WORD = 1'b0;
  logic [7:0]  CMD_CODE = 8'h00;
  logic [15:0] CMD_WDATA = 16'h0000;
  logic [15:0] TEMP_LIN = 16'h0019;
  logic [15:0] VIN_LIN = 16'h000C;
  logic        EN_REQ = 1'b1;
  logic        OTHER_SHUTDOWN = 1'b0;
  logic        RSP_VALID, RSP_ERR, OUT_EN, ALERT_LINE_I, ALERT_LINE_O, ALERT_LINE_OE;
  logic        prev_en = 1'b0;
  logic [15:0] RSP_RDATA;
  logic [15:0] rd;
  logic [2:0]  n, t;
  int          errors = 0, n_tests = 0, rises = 0, low = 0, gap = 0;

  always #2 CORE_CLK = ~CORE_CLK;

  frr_top #(.RETRY_STEP_CYC(STEP)) uut (
    .CORE_CLK(CORE_CLK), .RST(RST), .CMD_VALID(CMD_VALID), .CMD_WRITE(CMD_WRITE), .CMD_WORD(CMD_WORD),
    .CMD_CODE(CMD_CODE), .CMD_WDATA(CMD_WDATA), .RSP_VALID(RSP_VALID), .RSP_ERR(RSP_ERR),
    .RSP_RDATA(RSP_RDATA), .TEMP_LIN(TEMP_LIN), .VIN_LIN(VIN_LIN), .EN_REQ(EN_REQ),
    .OTHER_SHUTDOWN(OTHER_SHUTDOWN), .OUT_EN(OUT_EN), .ALERT_LINE_I(ALERT_LINE_I),
    .ALERT_LINE_O(ALERT_LINE_O), .ALERT_LINE_OE(ALERT_LINE_OE));
  frr_host_model host (.alert_o(ALERT_LINE_O), .alert_oe(ALERT_LINE_OE), .alert_wire(ALERT_LINE_I));

  // ------
  // Restart counter and off time before each restart
  // ------
  always @(posedge CORE_CLK) begin
    if (OUT_EN && !prev_en) begin
      rises = rises + 1;
      gap = low;
    end
    low = OUT_EN ? 0 : low + 1;
    prev_en = OUT_EN;
  end

  // ------
  // Command port tasks
  // ------
  task automatic cyc(input int k);
    repeat (k) @(negedge CORE_CLK);
  endtask
  task automatic cmd(input logic w, input logic wd, input logic [7:0] c, input logic [15:0] d);
    @(negedge CORE_CLK);
    CMD_VALID = 1'b1;
    CMD_WRITE = w;
    CMD_WORD = wd;
    CMD_CODE = c;
    CMD_WDATA = d;
    @(negedge CORE_CLK);
    CMD_VALID = 1'b0;
    `CHK(RSP_VALID, 1'b1)
    rd = RSP_RDATA;
  endtask
  task automatic wr(input logic wd, input logic [7:0] c, input logic [15:0] d, input logic e);
    cmd(1'b1, wd, c, d);
    `CHK(RSP_ERR, e)
  endtask
  task automatic rdc(input logic wd, input logic [7:0] c, input logic [15:0] x, input logic e);
    cmd(1'b0, wd, c, 16'h0000);
    `CHK({RSP_ERR, rd}, {e, e ? 16'h0000 : x})
  endtask
  task automatic clear();
    wr(1'b0, 8'h03, 16'h0000, 1'b0);
    cyc(3);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #20000;
    errors++;
    summarize();
  end

  initial begin
    cyc(5);
    RST = 1'b0;
    cyc(2);
    rdc(1'b0, 8'h54, 16'h00C0, 1'b0);
    rdc(1'b0, 8'h56, 16'h00C0, 1'b0);
    rdc(1'b1, 8'h55, 16'h000F, 1'b0);
    rdc(1'b1, 8'h52, 16'h07E7, 1'b0);
    rdc(1'b1, 8'h57, 16'h000E, 1'b0);
    rdc(1'b1, 8'h53, 16'h07D8, 1'b0);
    wr(1'b1, 8'h53, 16'h07DD, 1'b0);
    rdc(1'b1, 8'h53, 16'h07DD, 1'b0);
    wr(1'b1, 8'h7E, 16'h0000, 1'b1);
    rdc(1'b0, 8'h03, 16'h0000, 1'b1);
    rdc(1'b1, 8'h54, 16'h0000, 1'b1);
    rdc(1'b1, 8'h60, 16'h0000, 1'b1);
    wr(1'b0, 8'h55, 16'h0014, 1'b1);
    wr(1'b1, 8'h56, 16'h0000, 1'b1);
    wr(1'b0, 8'h56, 16'hA5C0, 1'b0);
    rdc(1'b0, 8'h56, 16'h00C0, 1'b0);
    wr(1'b1, 8'h55, 16'h0012, 1'b0);
    rdc(1'b1, 8'h55, 16'h0012, 1'b0);
    VIN_LIN = 16'h0012;
    cyc(4);
    `CHK(OUT_EN, 1'b1)
    VIN_LIN = 16'h0013;
    cyc(3);
    `CHK({OUT_EN, ALERT_LINE_OE, ALERT_LINE_I}, 3'h2)
    cmd(1'b0, 1'b1, 8'h7E, 16'h0000);
    `CHK(rd & 16'h8003, 16'h8002)
    VIN_LIN = 16'h000E;
    cyc(8);
    `CHK(OUT_EN, 1'b0)
    VIN_LIN = 16'h000D;
    cyc(3);
    `CHK(OUT_EN, 1'b1)
    clear();
    `CHK(ALERT_LINE_OE, 1'b0)
    TEMP_LIN = 16'h07CE;
    cyc(3);
    `CHK(OUT_EN, 1'b0)
    TEMP_LIN = 16'h07E7;
    cyc(8);
    `CHK(OUT_EN, 1'b0)
    TEMP_LIN = 16'h07EC;
    cyc(3);
    `CHK(OUT_EN, 1'b1)
    cmd(1'b0, 1'b1, 8'h7E, 16'h0000);
    `CHK(rd[1:0], 2'h1)
    clear();
    for (int m = 0; m < 2; m++) begin
      wr(1'b0, 8'h54, {8'h00, m[1:0], 6'h00}, 1'b0);
      TEMP_LIN = 16'h07CE;
      cyc(4);
      `CHK({OUT_EN, ALERT_LINE_OE}, 2'h3)
      TEMP_LIN = 16'h0019;
      clear();
      `CHK(ALERT_LINE_OE, 1'b0)
    end
    wr(1'b0, 8'h54, 16'h0080, 1'b0);
    TEMP_LIN = 16'h07CE;
    cyc(2);
    `CHK(OUT_EN, 1'b0)
    TEMP_LIN = 16'h0019;
    cyc(4 * STEP);
    `CHK(OUT_EN, 1'b0)
    clear();
    `CHK(OUT_EN, 1'b1)
    for (int i = 0; i < 2; i++) begin
      n = i ? 3'h3 : 3'h1;
      t = i ? 3'h2 : 3'h0;
      wr(1'b0, 8'h56, {8'h00, 2'h2, n, t}, 1'b0);
      rises = 0;
      VIN_LIN = 16'h0014;
      cyc((n + 2) * (t + 1) * STEP + 20);
      `CHK(rises, int'(n))
      `CHK(gap >= (t + 1) * STEP && gap <= (t + 1) * STEP + 2, 1'b1)
      cmd(1'b0, 1'b1, 8'h7E, 16'h0000);
      `CHK({OUT_EN, rd[7:5]}, {1'b0, n})
      VIN_LIN = 16'h000C;
      clear();
      cmd(1'b0, 1'b1, 8'h7E, 16'h0000);
      `CHK({OUT_EN, rd[7:5]}, 4'h8)
    end
    wr(1'b0, 8'h56, 16'h0090, 1'b0);
    VIN_LIN = 16'h0014;
    cyc(3);
    VIN_LIN = 16'h000C;
    cyc(3 * STEP + 10);
    cmd(1'b0, 1'b1, 8'h7E, 16'h0000);
    `CHK({OUT_EN, rd[7:5], rd[1]}, 5'h11)
    clear();
    wr(1'b0, 8'h56, 16'h00B8, 1'b0);
    rises = 0;
    VIN_LIN = 16'h0014;
    cyc(14 * STEP);
    `CHK(rises > 7, 1'b1)
    OTHER_SHUTDOWN = 1'b1;
    cyc(3);
    rises = 0;
    cyc(4 * STEP);
    `CHK(rises, 0)
    OTHER_SHUTDOWN = 1'b0;
    VIN_LIN = 16'h000C;
    clear();
    cyc(3 * STEP);
    `CHK(OUT_EN, 1'b1)
    EN_REQ = 1'b0;
    cyc(3);
    `CHK(OUT_EN, 1'b0)
    EN_REQ = 1'b1;
    cyc(3);
    `CHK(OUT_EN, 1'b1)
    summarize();
  end
endmodule // tb_top
